// ### include/sdf_pkg.sv
// Purpose: shared constants and types of the serial audio input deframer
// Assumes: single 200 MHz system clock, pins sampled through two flops
// Notes:   framing and width encodings are configuration input codes
package sdf_pkg;
    localparam int unsigned CLK_PERIOD_PS   = 5000;
    localparam int unsigned MAX_WIDTH       = 24;
    localparam int unsigned FRAME_BITS      = 64;
    localparam int unsigned SLOT_BITS       = 32;
    localparam int unsigned SYNC_STAGES     = 2;
    localparam int unsigned OSR_LOW         = 256;
    localparam int unsigned OSR_HIGH        = 384;
    // biphase cells per frame: 64 bits of two cells each
    localparam int unsigned BIPHASE_CELLS   = 128;
    localparam int unsigned DIV_LOW         = OSR_LOW / BIPHASE_CELLS;
    localparam int unsigned DIV_HIGH        = OSR_HIGH / BIPHASE_CELLS;
    localparam logic [2:0]  DIV_LOW_3       = 3'(DIV_LOW);
    localparam logic [2:0]  DIV_HIGH_3      = 3'(DIV_HIGH);
    localparam logic [5:0]  RJ_PAD_BASE     = 6'h20;

    typedef enum logic [1:0] {
        SDF_FMT_I2S   = 2'h0,
        SDF_FMT_LEFT  = 2'h1,
        SDF_FMT_RIGHT = 2'h2
    } sdf_fmt_t;

    typedef enum logic [1:0] {
        SDF_W16 = 2'h0,
        SDF_W18 = 2'h1,
        SDF_W20 = 2'h2,
        SDF_W24 = 2'h3
    } sdf_width_t;

    // gray codes along idle -> wait -> shift
    typedef enum logic [1:0] {
        SDF_ST_IDLE  = 2'b00,
        SDF_ST_WAIT  = 2'b01,
        SDF_ST_SHIFT = 2'b11
    } sdf_state_t;

    function automatic logic [5:0] sdf_bits(input sdf_width_t w);
        case (w)
            SDF_W16: sdf_bits = 6'h10;
            SDF_W18: sdf_bits = 6'h12;
            SDF_W20: sdf_bits = 6'h14;
            default: sdf_bits = 6'h18;
        endcase
    endfunction
endpackage

// ### verilog/sdf_biphase_div.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: biphase cell strobe from the oversampling clock
// Assumes: oversampling_clock is a pin, sampled on clock_i
// Notes:   strobe once every DIV oversampling rising edges
////////////////////////////////////////////////////////////////////////////////
module sdf_biphase_div
    import sdf_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic nrst_i,
    input  wire logic clk_en_i,
    input  wire logic osr_384_i,
    input  wire logic oversampling_clock_i,
    output logic      cell_strobe_o
);
    logic [1:0] sync_q;
    logic [1:0] sync_d;
    logic       prev_q;
    logic       prev_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic       stb_q;
    logic       stb_d;
    logic [2:0] div;

    always_comb begin
        div    = osr_384_i ? DIV_HIGH_3 : DIV_LOW_3;
        sync_d = {sync_q[0], oversampling_clock_i};
        prev_d = sync_q[1];
        cnt_d  = cnt_q;
        stb_d  = 1'b0;
        if (sync_q[1] && !prev_q) begin
            if (cnt_q >= div - 3'h1) begin
                cnt_d = 3'h0;
                stb_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_q <= 2'h0;
            prev_q <= 1'b0;
            cnt_q  <= 3'h0;
            stb_q  <= 1'b0;
        end else if (clk_en_i) begin
            sync_q <= sync_d;
            prev_q <= prev_d;
            cnt_q  <= cnt_d;
            stb_q  <= stb_d;
        end
    end

    assign cell_strobe_o = stb_q;

    strobe_pulse_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        clk_en_i && stb_q |=> !stb_q)
        else $error("cell strobe wider than one cycle");
endmodule // sdf_biphase_div

// ### verilog/sdf_deframer.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: serial audio input deframer feeding the biphase encoder
// Assumes: bit clock, frame sync and data are pins, oversampled on clock_i
// Notes:   right-justified data is taken from the slot's tail
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Serial data is accepted in I2S, left-justified or right-justified framing.
// - Sample widths of 16, 18, 20 and 24 bits are selected by configuration.
// - Data bits are captured at the rising edge of the bit clock.
// - In left and right-justified framing a high frame sync marks the left slot.
// - Right-justified data starts 32 minus the width bits after the edge, so its LSB ends the slot.
// - In I2S framing a low frame sync marks the left slot.
// - In I2S framing the MSB comes one bit clock after the frame sync edge.
// - In left-justified framing the MSB comes right at the frame sync edge.
// - The biphase cell clock is the oversampling clock divided for 256 or 384 times fs.
module sdf_deframer
    import sdf_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire logic                  nrst_i,
    input  wire logic                  clk_en_i,
    input  wire sdf_pkg::sdf_fmt_t     format_i,
    input  wire sdf_pkg::sdf_width_t   width_i,
    input  wire logic                  osr_384_i,
    input  wire logic                  bit_clock_i,
    input  wire logic                  frame_sync_i,
    input  wire logic                  serial_sample_in_i,
    input  wire logic                  oversampling_clock_i,
    output logic [sdf_pkg::MAX_WIDTH-1:0] sample_o,
    output logic                       sample_left_o,
    output logic                       sample_valid_o,
    output logic                       cell_strobe_o
);
    import sdf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and bit clock edge
    logic [SYNC_STAGES-1:0] bck_s_q;
    logic [SYNC_STAGES-1:0] bck_s_d;
    logic [SYNC_STAGES-1:0] fs_s_q;
    logic [SYNC_STAGES-1:0] fs_s_d;
    logic [SYNC_STAGES-1:0] dat_s_q;
    logic [SYNC_STAGES-1:0] dat_s_d;
    logic                   bck_prev_q;
    logic                   bck_prev_d;
    logic                   fs_prev_q;
    logic                   fs_prev_d;
    logic                   rise;

    always_comb begin
        bck_s_d    = {bck_s_q[0], bit_clock_i};
        fs_s_d     = {fs_s_q[0], frame_sync_i};
        dat_s_d    = {dat_s_q[0], serial_sample_in_i};
        bck_prev_d = bck_s_q[1];
        // frame sync level seen at the last bit clock rise
        fs_prev_d  = rise ? fs_s_q[1] : fs_prev_q;
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bck_s_q    <= '0;
            fs_s_q     <= '0;
            dat_s_q    <= '0;
            bck_prev_q <= 1'b0;
            fs_prev_q  <= 1'b0;
        end else if (clk_en_i) begin
            bck_s_q    <= bck_s_d;
            fs_s_q     <= fs_s_d;
            dat_s_q    <= dat_s_d;
            bck_prev_q <= bck_prev_d;
            fs_prev_q  <= fs_prev_d;
        end
    end

    assign rise = bck_s_q[1] && !bck_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // slot sequencer
    sdf_state_t             st_q;
    sdf_state_t             st_d;
    logic [5:0]             pos_q;
    logic [5:0]             pos_d;
    logic [5:0]             left_q;
    logic [5:0]             left_d;
    logic [MAX_WIDTH-1:0]   sh_q;
    logic [MAX_WIDTH-1:0]   sh_d;
    logic                   slot_l_q;
    logic                   slot_l_d;
    logic [MAX_WIDTH-1:0]   out_q;
    logic [MAX_WIDTH-1:0]   out_d;
    logic                   out_l_q;
    logic                   out_l_d;
    logic                   vld_q;
    logic                   vld_d;
    logic [5:0]             nbits;
    logic [5:0]             skip;
    logic                   fs_edge;
    logic                   is_left;
    logic [MAX_WIDTH-1:0]   shifted;

    always_comb begin
        nbits   = sdf_bits(width_i);
        fs_edge = fs_s_q[1] != fs_prev_q;
        if (format_i == SDF_FMT_I2S) begin
            is_left = !fs_s_q[1];
        end else begin
            is_left = fs_s_q[1];
        end
        case (format_i)
            SDF_FMT_I2S:   skip = 6'h1;
            SDF_FMT_LEFT:  skip = 6'h0;
            default:       skip = RJ_PAD_BASE - nbits;
        endcase
        shifted  = {sh_q[MAX_WIDTH-2:0], dat_s_q[1]};
        st_d     = st_q;
        pos_d    = pos_q;
        left_d   = left_q;
        sh_d     = sh_q;
        slot_l_d = slot_l_q;
        out_d    = out_q;
        out_l_d  = out_l_q;
        vld_d    = 1'b0;
        if (rise) begin
            if (fs_edge) begin
                slot_l_d = is_left;
                pos_d    = 6'h0;
                sh_d     = '0;
                if (skip == 6'h0) begin
                    sh_d   = {{(MAX_WIDTH-1){1'b0}}, dat_s_q[1]};
                    left_d = nbits - 6'h1;
                    st_d   = SDF_ST_SHIFT;
                end else begin
                    left_d = nbits;
                    st_d   = SDF_ST_WAIT;
                end
            end else begin
                pos_d = pos_q + 6'h1;
                case (st_q)
                    SDF_ST_WAIT: begin
                        if (pos_q + 6'h1 >= skip) begin
                            sh_d   = shifted;
                            left_d = left_q - 6'h1;
                            st_d   = SDF_ST_SHIFT;
                        end
                    end
                    SDF_ST_SHIFT: begin
                        if (left_q != 6'h0) begin
                            sh_d   = shifted;
                            left_d = left_q - 6'h1;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (st_q == SDF_ST_SHIFT && left_q == 6'h0) begin
            // left-align the sample in the output word
            out_d   = sh_q << (6'(MAX_WIDTH) - nbits);
            out_l_d = slot_l_q;
            vld_d   = 1'b1;
            st_d    = (rise && fs_edge) ? st_d : SDF_ST_IDLE;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q     <= SDF_ST_IDLE;
            pos_q    <= 6'h0;
            left_q   <= 6'h0;
            sh_q     <= '0;
            slot_l_q <= 1'b0;
            out_q    <= '0;
            out_l_q  <= 1'b0;
            vld_q    <= 1'b0;
        end else if (clk_en_i) begin
            st_q     <= st_d;
            pos_q    <= pos_d;
            left_q   <= left_d;
            sh_q     <= sh_d;
            slot_l_q <= slot_l_d;
            out_q    <= out_d;
            out_l_q  <= out_l_d;
            vld_q    <= vld_d;
        end
    end

    assign sample_o       = out_q;
    assign sample_left_o  = out_l_q;
    assign sample_valid_o = vld_q;

    ////////////////////////////////////////////////////////////////////////////
    // biphase cell clock
    sdf_biphase_div u_div (
        .clock_i              (clock_i),
        .nrst_i               (nrst_i),
        .clk_en_i             (clk_en_i),
        .osr_384_i            (osr_384_i),
        .oversampling_clock_i (oversampling_clock_i),
        .cell_strobe_o        (cell_strobe_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // last bit clock rise of a 32-bit slot, counted from the frame edge
    localparam logic [5:0] RJ_LAST_POS = 6'(SLOT_BITS - 1);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    vld_pulse_a: assert property (clk_en_i && vld_q |=> !vld_q)
        else $error("sample valid longer than one cycle");
    vld_cause_a: assert property (clk_en_i && vld_d |-> pos_q == skip + nbits - 6'h1)
        else $error("sample without complete slot");
    lj_start_a: assert property (clk_en_i && rise && fs_edge && format_i == SDF_FMT_LEFT
        |=> st_q == SDF_ST_SHIFT)
        else $error("left-justified msb not taken at edge");
    i2s_wait_a: assert property (clk_en_i && rise && fs_edge && format_i == SDF_FMT_I2S
        |=> st_q == SDF_ST_WAIT)
        else $error("i2s msb not delayed");
    i2s_side_a: assert property (clk_en_i && rise && fs_edge && format_i == SDF_FMT_I2S
        |=> slot_l_q == !fs_prev_q)
        else $error("i2s channel inverted");
    lj_side_a: assert property (clk_en_i && rise && fs_edge && format_i != SDF_FMT_I2S
        |=> slot_l_q == fs_prev_q)
        else $error("justified channel inverted");
    rj_skip_a: assert property (clk_en_i && vld_d && format_i == SDF_FMT_RIGHT
        |-> pos_q == RJ_LAST_POS)
        else $error("right-justified lsb not at slot end");
    cnt_width_a: assert property (clk_en_i && rise && fs_edge && format_i == SDF_FMT_LEFT
        |=> left_q == nbits - 6'h1)
        else $error("bit count does not match width");
    cap_rise_a: assert property (clk_en_i && st_q == SDF_ST_SHIFT && !rise
        |=> $stable(sh_q))
        else $error("data shifted off the rising edge");
    slot_start_a: assert property (clk_en_i && rise && fs_edge |=> st_q != SDF_ST_IDLE)
        else $error("frame edge did not open a slot");

    i2s_c: cover property (vld_q && format_i == SDF_FMT_I2S);
    lj_c:  cover property (vld_q && format_i == SDF_FMT_LEFT);
    rj_c:  cover property (vld_q && format_i == SDF_FMT_RIGHT && width_i == SDF_W20);
    div_c: cover property (cell_strobe_o && osr_384_i);
endmodule // sdf_deframer

// ### sim/sdf_source_model.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: serial audio source driving bit clock, frame sync and data pins
// Assumes: bit clock of 16 system cycles, held still between frames
// Notes:   pins change with the falling bit clock; unused slot bits are random
////////////////////////////////////////////////////////////////////////////////
module sdf_source_model
    import sdf_pkg::*;
(
    input  wire logic clock_i,
    output logic      bit_clock_o,
    output logic      frame_sync_o,
    output logic      data_o
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int HALF = 8;

    initial begin
        bit_clock_o  = 1'b0;
        frame_sync_o = 1'b0;
        data_o       = 1'b0;
    end

    task automatic half_bit();
        repeat (HALF) @(posedge clock_i);
        #1;
    endtask

    // new values at the falling edge stay stable around the rising edge
    task automatic put_bit(input logic fs, input logic d);
        half_bit();
        bit_clock_o  = 1'b0;
        frame_sync_o = fs;
        data_o       = d;
        half_bit();
        bit_clock_o  = 1'b1;
    endtask

    // two lead-in bits in the right slot level, then one 64-bit frame
    task automatic send_frame(input sdf_fmt_t fmt, input int w, input logic [23:0] l,
                              input logic [23:0] r);
        logic left_fs;
        int   start;
        int   p;
        left_fs = (fmt != SDF_FMT_I2S);
        start   = (fmt == SDF_FMT_I2S) ? 1 : (fmt == SDF_FMT_LEFT) ? 0 : 32 - w;
        put_bit(~left_fs, 1'b0);
        put_bit(~left_fs, 1'b1);
        for (int s = 0; s < 64; s++) begin
            p = (s % 32) - start;
            if (p >= 0 && p < w) begin
                put_bit(left_fs ^ (s >= 32), (s < 32) ? l[w-1-p] : r[w-1-p]);
            end else begin
                put_bit(left_fs ^ (s >= 32), 1'($urandom));
            end
        end
        half_bit();
        bit_clock_o = 1'b0;
        data_o      = ~data_o;
    endtask
endmodule // sdf_source_model

// ### sim/sdf_deframer_tb.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench of the serial audio input deframer
// Assumes: 200 MHz clock, source model on the serial pins
// Notes:   every framing and width, corner then random samples
////////////////////////////////////////////////////////////////////////////////
module sdf_deframer_tb
    import sdf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

`define CHECK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin \
    bad_count++; $display("[FAIL] %0t %s", $time, msg); end end

    logic                 clock_i;
    logic                 nrst_i;
    logic                 clk_en_i;
    sdf_fmt_t             format_i;
    sdf_width_t           width_i;
    logic                 osr_384_i;
    logic                 osc;
    logic                 bclk;
    logic                 fsync;
    logic                 serial_sample_in;
    logic [MAX_WIDTH-1:0] sample_o;
    logic                 sample_left_o;
    logic                 sample_valid_o;
    logic                 cell_strobe_o;
    logic [24:0]          got_q[$];
    int                   gap;
    int                   last_gap;
    int                   bad_count;
    int                   checks_done;
    int                   strobes;
    int                   strobes_at;
    logic                 held;

    sdf_deframer sdf_deframer_i (
        .clock_i(clock_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
        .format_i(format_i), .width_i(width_i), .osr_384_i(osr_384_i),
        .bit_clock_i(bclk), .frame_sync_i(fsync), .serial_sample_in_i(serial_sample_in),
        .oversampling_clock_i(osc), .sample_o(sample_o), .sample_left_o(sample_left_o),
        .sample_valid_o(sample_valid_o), .cell_strobe_o(cell_strobe_o)
    );

    sdf_source_model sdf_source_model_i (
        .clock_i(clock_i), .bit_clock_o(bclk), .frame_sync_o(fsync), .data_o(serial_sample_in)
    );

    ////////////////////////////////////////////////////////////////////////////
    always #2.5 clock_i = ~clock_i;

    // free-running oversampling clock, period of 8 system cycles
    always begin
        repeat (4) @(posedge clock_i);
        #1 osc = ~osc;
    end

    always @(posedge clock_i) begin
        if (sample_valid_o === 1'b1) begin
            got_q.push_back({sample_left_o, sample_o});
        end
        if (cell_strobe_o === 1'b1) begin
            last_gap = gap;
            gap = 1;
            strobes++;
        end else begin
            gap++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic int wbits(input sdf_width_t wc);
        return (wc == SDF_W16) ? 16 : (wc == SDF_W18) ? 18 : (wc == SDF_W20) ? 20 : 24;
    endfunction

    // output is MSB-aligned with the channel flag on top
    function automatic logic [24:0] exp_word(input logic lf, input logic [23:0] s, input int w);
        return {lf, s << (24 - w)};
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic run_case(input sdf_fmt_t f, input sdf_width_t wc, input bit corner);
        int          w;
        logic [23:0] m;
        logic [23:0] l;
        logic [23:0] r;
        w = wbits(wc);
        m = (24'h1 << w) - 24'h1;
        l = corner ? m : 24'($urandom) & m;
        r = corner ? 24'h1 : 24'($urandom) & m;
        @(posedge clock_i);
        #1;
        format_i = f;
        width_i  = wc;
        got_q.delete();
        sdf_source_model_i.send_frame(f, w, l, r);
        repeat (20) @(posedge clock_i);
        `CHECK(got_q.size(), 2, "sample count")
        if (got_q.size() == 2) begin
            `CHECK(got_q[0], exp_word(1'b1, l, w), "left sample")
            `CHECK(got_q[1], exp_word(1'b0, r, w), "right sample")
        end
        $display("test format %0d width %0d done", f, w);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i   = 1'b0;
        nrst_i    = 1'b0;
        clk_en_i  = 1'b1;
        format_i  = SDF_FMT_I2S;
        width_i   = SDF_W16;
        osr_384_i = 1'b0;
        osc       = 1'b0;
        void'($urandom(2813));
        repeat (20) @(posedge clock_i);
        #1 nrst_i = 1'b1;
        for (int f = 0; f < 3; f++) begin
            for (int wc = 0; wc < 4; wc++) begin
                run_case(sdf_fmt_t'(f), sdf_width_t'(wc), 1'b1);
                run_case(sdf_fmt_t'(f), sdf_width_t'(wc), 1'b0);
            end
        end
        // a reset in mid-run clears the held sample, then framing restarts
        #1 nrst_i = 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
        `CHECK({sample_valid_o, sample_left_o, sample_o}, 26'h0, "sample after reset")
        nrst_i = 1'b1;
        run_case(SDF_FMT_I2S, SDF_W24, 1'b0);
        for (int o = 0; o < 2; o++) begin
            @(posedge clock_i);
            #1 osr_384_i = o[0];
            repeat (200) @(posedge clock_i);
            `CHECK(last_gap, 8 * ((o == 1) ? OSR_HIGH : OSR_LOW) / BIPHASE_CELLS, "strobe gap")
            $display("test strobe ratio %0d done", o);
        end
        // a low clock enable holds the divider, its strobe included
        #1 clk_en_i = 1'b0;
        repeat (2) @(posedge clock_i);
        #1 held = cell_strobe_o;
        strobes_at = strobes;
        repeat (100) @(posedge clock_i);
        #1;
        `CHECK(strobes, strobes_at + (held ? 100 : 0), "strobe while disabled")
        clk_en_i = 1'b1;
        $display("test clock enable done");
        finish_test();
    end

    initial begin
        repeat (60000) @(posedge clock_i);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
endmodule // sdf_deframer_tb
